// >>> dv/tac_spi_host.sv
/*
 * Serial host model: mode 0 master, MSB first, slow clock.
 * Assumes callers enter its task between sys_clk edges.
 */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Host model
// ==========================================
module tac_spi_host (
    // Clock
    input wire logic sys_clk,
    // Serial pins
    input wire logic spi_miso,
    output var logic spi_cs_n,
    output var logic spi_sclk,
    output var logic spi_mosi
);
    localparam int HALF = 6;  // sys_clk cycles per sclk phase
    // Idle bus, clock stands low
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b1;
    end
    // Command byte, then an optional 16-bit word
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                        input bit word, output logic [15:0] rd);
        logic [23:0] sh;
        int n;
        sh = {cmd, wd};
        n = word ? 24 : 8;
        rd = 16'h0000;
        @(negedge sys_clk);
        spi_cs_n = 1'b0;
        repeat (HALF) @(negedge sys_clk);
        for (int i = 0; i < n; i++) begin
            spi_mosi = sh[23 - i];
            repeat (HALF) @(negedge sys_clk);
            if (i >= 8)
                rd[23 - i] = spi_miso;
            spi_sclk = 1'b1;
            repeat (HALF) @(negedge sys_clk);
            spi_sclk = 1'b0;
        end
        repeat (HALF) @(negedge sys_clk);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;  // Released line shows no stale bit
        repeat (HALF) @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

// >>> dv/tac_touch_config_checker.sv
/*
 * Port checker for the touch converter configuration block.
 * Assumes one sys_clk domain and the async active-low resetn.
 */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Checker
// ==========================================
module tac_touch_config_checker #(
    parameter US_CYCLES = 20  // Timer scale, unused here
) (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       resetn,
    // Serial port
    input wire logic       spi_cs_n,
    input wire logic       spi_miso_oe,
    // Converter side
    input wire logic       panel_drive,
    input wire logic       adc_sample,
    input wire logic       adc_clk_en,
    input wire logic       adc_power,
    input wire logic       conv_done
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [7:0] samp_cnt;  // Length of current sample phase
    // Count consecutive sample cycles
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            samp_cnt <= 8'h00;
        else
            samp_cnt <= adc_sample ? samp_cnt + 8'h01 : 8'h00;
    end
    // Fifteen cycles of sampling at the least
    sequence s_sample_hold;
        adc_sample [*8] ##1 adc_sample [*7];
    endsequence
    a_sample_min: assert property ($rose(adc_sample) |-> s_sample_hold)
        else $error("sample phase too short");
    a_sample_len: assert property ($fell(adc_sample) |->
        (samp_cnt == 8'h0f || samp_cnt == 8'h19))
        else $error("sample phase length wrong");
    a_sample_drive: assert property (adc_sample |-> panel_drive)
        else $error("sampling without panel drive");
    a_clk_convert: assert property (adc_clk_en |-> panel_drive && !adc_sample)
        else $error("converter clock outside convert");
    a_clk_spacing: assert property (adc_clk_en |=> !adc_clk_en [*4])
        else $error("converter clock faster than oscillator");
    a_power_start: assert property ($rose(panel_drive) |-> ##[0:1] adc_power)
        else $error("scan started unpowered");
    a_oe_follow: assert property (!spi_cs_n [*5] |-> spi_miso_oe)
        else $error("miso not driven while selected");
    a_oe_release: assert property (spi_cs_n [*5] |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    a_done_pulse: assert property (conv_done |=> !conv_done)
        else $error("done longer than one cycle");
endmodule

bind tac_touch_config tac_touch_config_checker #(.US_CYCLES(US_CYCLES)) tac_chk_i (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .spi_cs_n    (spi_cs_n),
    .spi_miso_oe (spi_miso_oe),
    .panel_drive (panel_drive),
    .adc_sample  (adc_sample),
    .adc_clk_en  (adc_clk_en),
    .adc_power   (adc_power),
    .conv_done   (conv_done)
);
`default_nettype wire

// >>> dv/tac_touch_config_test.sv
/*
 * Testbench of the touch converter configuration block.
 * Assumes the host model and checker beside it, timers at 1 cycle/us.
 */
`timescale 1ns/10ps
`default_nettype none
`include "tac_consts.vh"
// ==========================================
// Testbench
// ==========================================
module tac_touch_config_test;
    localparam int US = 1;  // Short timers
    localparam logic [7:0] WR = {1'b0, `TAC_CFG_ADDR, 3'b000};
    localparam logic [7:0] RD = {1'b0, `TAC_CFG_ADDR, 3'b001};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic pen_touch = 1'b0;
    wire logic cs_n, sclk, mosi, miso, miso_oe;
    wire logic adc_clk_en, res_sel, conv_done, irq_n;
    logic panel_drive, adc_sample, adc_power;  // Variables, so wait_for can watch them
    time t_drive = 0;
    time t_samp = 0;
    wire logic [1:0] coord_sel;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic [15:0] rv;
    tac_spi_host tac_spi_host_i (.sys_clk(sys_clk), .spi_miso(miso),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi));
    tac_touch_config #(.US_CYCLES(US)) tac_touch_config_i (
        .sys_clk(sys_clk), .resetn(resetn), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
        .pen_touch(pen_touch), .panel_drive(panel_drive), .adc_sample(adc_sample),
        .adc_clk_en(adc_clk_en), .adc_power(adc_power), .resolution_select(res_sel),
        .coord_sel(coord_sel), .conv_done(conv_done), .touch_data_irq_pin_n(irq_n));
    always #25 sys_clk = ~sys_clk;
    // Rise times of panel drive and sampling, for the settle measurement
    always @(posedge panel_drive) t_drive <= $time;
    always @(posedge adc_sample) t_samp <= $time;
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] d);
        logic [15:0] x;
        tac_spi_host_i.xfer(WR, d, 1'b1, x);
    endtask
    task automatic rd(output logic [15:0] d);
        tac_spi_host_i.xfer(RD, 16'h0000, 1'b1, d);
    endtask
    task automatic start(input logic [7:0] b);
        logic [15:0] x;
        tac_spi_host_i.xfer(b, 16'h0000, 1'b0, x);
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int n = 0; n < lim && s !== v; n++)
            @(negedge sys_clk);
    endtask
    task automatic t_fields();
        logic [15:0] w[3] = '{16'h2ffe, 16'h1001, 16'h0000};
        foreach (w[i]) begin
            wr(w[i]);
            rd(rv);
            chk(rv, w[i] | 16'h4000);
        end
        pen_touch = 1'b1;
        rd(rv);
        chk(rv, 32'h0000c000);
        pen_touch = 1'b0;
        tac_spi_host_i.xfer(8'h68, 16'hffff, 1'b1, rv);
        tac_spi_host_i.xfer(8'h69, 16'h0000, 1'b1, rv);
        chk(rv, 32'h0);
        rd(rv);
        chk(rv, 32'h4000);
        $display("test fields done");
    endtask
    task automatic t_timing();
        logic [15:0] cfg[3] = '{16'h0900, 16'h1201, 16'h0100};
        int sp[3] = '{10, 20, 5};
        int st[3] = '{100, 500, 100};
        int settle, samp, conv, ticks;
        foreach (cfg[i]) begin
            wr(cfg[i]);
            start(8'h80);
            settle = 0;
            samp = 0;
            conv = 0;
            ticks = 0;
            wait_for(adc_sample, 1'b1, 3000);
            settle = int'((t_samp - t_drive) / 50);  // Drive rise to sample rise
            for (; adc_sample === 1'b1 && samp < 100; samp++) @(negedge sys_clk);
            for (; conv_done !== 1'b1 && conv < 2000; conv++) begin
                ticks += adc_clk_en;
                @(negedge sys_clk);
            end
            chk(settle >= st[i] * US && settle <= st[i] * US + 3, 1);
            chk(samp, cfg[i][0] ? 25 : 15);
            chk(ticks, 10);
            chk(conv >= 9 * sp[i] && conv <= 11 * sp[i], 1);
            chk(coord_sel, 2'd1);
            wait_for(adc_power, 1'b0, 8000);
        end
        $display("test timing done");
    endtask
    task automatic t_stop();
        wr(16'h0500);
        start(8'h80);
        rd(rv);
        chk(rv, 16'h0500);
        chk(adc_power, 1);
        wr(16'h4500);
        repeat (3) @(negedge sys_clk);
        chk({adc_power, panel_drive}, 0);
        start(8'h84);
        chk({adc_power, res_sel}, 3);
        start(8'h85);
        repeat (3) @(negedge sys_clk);
        chk(adc_power, 0);
        rd(rv);
        chk(rv, 16'h6500);
        wr(16'h0000);
        $display("test stop done");
    endtask
    task automatic t_modes();
        wr(16'h8100);
        pen_touch = 1'b1;
        wait_for(panel_drive, 1'b1, 3000);
        chk(panel_drive, 1);
        pen_touch = 1'b0;
        wait_for(adc_power, 1'b0, 10000);
        wr(16'h0002);
        pen_touch = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk({irq_n, adc_power}, 0);
        pen_touch = 1'b0;
        repeat (10) @(negedge sys_clk);
        chk(irq_n, 1);
        repeat (1000) @(negedge sys_clk);
        chk(adc_power, 0);
        $display("test modes done");
    endtask
    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(negedge sys_clk);
        chk({irq_n, adc_power, miso_oe}, 4);
        resetn = 1'b1;
        rd(rv);
        chk(rv, `TAC_RD_RESET);
        $display("test reset done");
        t_fields();
        t_timing();
        t_stop();
        t_modes();
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> logic/tac_consts.vh
/*
 * Constants for the touch converter configuration block: SPI command
 * layout, configuration word fields, reset values and timing tables.
 * Assumes the including module runs on a 20 MHz system clock.
 */
`ifndef TAC_CONSTS_VH
`define TAC_CONSTS_VH

// ==========================================================
// Clock and timing
// ==========================================================
`define TAC_CLK_KHZ          20000
`define TAC_OSC_KHZ          4000
`define TAC_OSC_DIV          (`TAC_CLK_KHZ / `TAC_OSC_KHZ)
`define TAC_US_CYCLES        (`TAC_CLK_KHZ / 1000)
`define TAC_LONG_SAMPLE_NS   500
`define TAC_LONG_SAMPLE_CYC  ((`TAC_LONG_SAMPLE_NS * `TAC_CLK_KHZ + 999999) / 1000000)
`define TAC_SAMPLE_OSC_CYC   3

// ==========================================================
// Command bytes
// ==========================================================
`define TAC_CB_KIND          7
`define TAC_CB_ADDR_HI       6
`define TAC_CB_ADDR_LO       3
`define TAC_CB_RM            2
`define TAC_CB_SWRST         1
`define TAC_CB_STS           0
`define TAC_CB_RNW           0
`define TAC_CFG_ADDR         4'hc
`define TAC_FN_XYZ           4'h0
`define TAC_FN_XY            4'h1

// ==========================================================
// Configuration word fields
// ==========================================================
`define TAC_F_PSM            15
`define TAC_F_STS            14
`define TAC_F_RM             13
`define TAC_F_CL_HI          12
`define TAC_F_CL_LO          11
`define TAC_F_PV_HI          10
`define TAC_F_PV_LO          8
`define TAC_F_PR_HI          7
`define TAC_F_PR_LO          5
`define TAC_F_SN_HI          4
`define TAC_F_SN_LO          2
`define TAC_F_DTW            1
`define TAC_F_LSM            0
`define TAC_RD_RESET         16'h4000
`define TAC_WR_RESET         16'h0000

// ==========================================================
// Settling, precharge and sense times in microseconds
// ==========================================================
`define TAC_PV_US {22'd100000, 22'd50000, 22'd10000, 22'd5000, 22'd1000, 22'd500, 22'd100, 22'd0}
`define TAC_PR_US {22'd1364, 22'd1300, 22'd1108, 22'd1044, 22'd340, 22'd276, 22'd84, 22'd20}
`define TAC_SN_US {22'd2656, 22'd2592, 22'd2144, 22'd2080, 22'd608, 22'd544, 22'd96, 22'd32}

`endif

// >>> logic/tac_touch_config.v
/*
 * Touch converter configuration register with its serial command port
 * and the scan sequencer it steers (settle, sample, convert, precharge,
 * sense). Assumes an SPI mode 0 master whose pins are asynchronous to
 * sys_clk and slow enough to be oversampled; pen_touch comes from the
 * analog touch comparator, also asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
`include "tac_consts.vh"

module tac_touch_config #(
    parameter US_CYCLES = `TAC_US_CYCLES  // System cycles per microsecond
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    // Serial command port
    input  wire        spi_cs_n,
    input  wire        spi_sclk,
    input  wire        spi_mosi,
    output reg         spi_miso,
    output reg         spi_miso_oe,
    // Touch panel and converter
    input  wire        pen_touch,
    output reg         panel_drive,
    output reg         adc_sample,
    output reg         adc_clk_en,
    output reg         adc_power,
    output reg         resolution_select,
    output reg  [1:0]  coord_sel,
    output reg         conv_done,
    output reg         touch_data_irq_pin_n
);

    // ==========================================================
    // States and local sizes
    // ==========================================================
    localparam [5:0] ST_IDLE   = 6'h01;
    localparam [5:0] ST_SETTLE = 6'h02;
    localparam [5:0] ST_SAMPLE = 6'h04;
    localparam [5:0] ST_CONV   = 6'h08;
    localparam [5:0] ST_PRECHG = 6'h10;
    localparam [5:0] ST_SENSE  = 6'h20;
    localparam integer OSC_LOAD  = `TAC_OSC_DIV - 1;                  // Oscillator reload
    localparam integer US_LOAD   = US_CYCLES - 1;                     // Microsecond reload
    localparam integer SAMP_BASE = `TAC_SAMPLE_OSC_CYC * `TAC_OSC_DIV - 1; // Count ends at 0
    localparam integer SAMP_LONG = `TAC_LONG_SAMPLE_CYC;              // Long sample extension
    // Packed lookup tables
    localparam [175:0] PV_T = `TAC_PV_US;
    localparam [175:0] PR_T = `TAC_PR_US;
    localparam [175:0] SN_T = `TAC_SN_US;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    reg  [3:0] sync1_reg;              // First stage, read only by second
    reg  [3:0] sync2_reg;              // Second stage: cs, sclk, mosi, pen
    reg        sclk_old_reg;           // Previous synchronised clock

    // Two flops per asynchronous pin
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // Idle pin levels, so no false edge or touch follows reset
            sync1_reg    <= 4'ha;
            sync2_reg    <= 4'ha;
            sclk_old_reg <= 1'b0;
        end else begin
            sync1_reg    <= {spi_cs_n, spi_sclk, spi_mosi, pen_touch};
            sync2_reg    <= sync1_reg;
            sclk_old_reg <= sync2_reg[2];
        end
    end

    wire cs_act  = ~sync2_reg[3];
    wire sclk_r  = cs_act & sync2_reg[2] & ~sclk_old_reg;
    wire sclk_f  = cs_act & ~sync2_reg[2] & sclk_old_reg;
    wire mosi_s  = sync2_reg[1];
    wire touch_s = sync2_reg[0];

    // ==========================================================
    // Register and serial state
    // ==========================================================
    reg        psm_reg;                // Pen mode select
    reg        sts_reg;                // Stop request
    reg        rm_reg;                 // Resolution select
    reg [1:0]  cl_reg;                 // Converter clock divider
    reg [2:0]  pv_reg;                 // Panel settle code
    reg [2:0]  pr_reg;                 // Precharge code
    reg [2:0]  sn_reg;                 // Sense code
    reg        dtw_reg;                // Wait touch detect
    reg        lsm_reg;                // Long sample mode
    reg [3:0]  fn_reg;                 // Converter function code
    reg        start_reg;              // Host start request
    reg [4:0]  bit_reg;                // Bit position in command
    reg [7:0]  cmd_reg;                // Latched command byte
    reg [15:0] sh_reg;                 // Receive shifter
    reg [15:0] tx_reg;                 // Transmit shifter
    reg        data_rdy_reg;           // Conversion result waiting
    reg [5:0]  st_reg;                 // Sequencer state
    reg [21:0] cnt_reg;                // Phase countdown
    reg [1:0]  crd_reg;                // Coordinate index

    wire [15:0] rx_word  = {sh_reg[14:0], mosi_s};
    wire        busy     = ~st_reg[0];
    // Read image: touch and idle flags, the rest verbatim
    wire [15:0] rd_word  = {touch_s, ~busy, rm_reg, cl_reg, pv_reg,
                            pr_reg, sn_reg, dtw_reg, lsm_reg};

    // ==========================================================
    // Serial command decode
    // ==========================================================
    // Mode 0: sample on rising edge, shift out on falling edge
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            psm_reg <= 1'b0;
            sts_reg <= 1'b0;
            rm_reg  <= 1'b0;
            cl_reg  <= 2'h0;
            pv_reg  <= 3'h0;
            pr_reg  <= 3'h0;
            sn_reg  <= 3'h0;
            dtw_reg <= 1'b0;
            lsm_reg <= 1'b0;
            fn_reg  <= 4'h0;
            start_reg <= 1'b0;
            bit_reg <= 5'h00;
            cmd_reg <= 8'h00;
            sh_reg  <= 16'h0000;
            tx_reg  <= 16'h0000;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            start_reg   <= 1'b0;
            spi_miso_oe <= cs_act;
            if (!cs_act) begin
                bit_reg <= 5'h00;                          // Frame ends with select
            end else if (sclk_r) begin
                sh_reg <= rx_word;
                if (bit_reg == 5'd7) begin
                    cmd_reg <= rx_word[7:0];
                    if (rx_word[`TAC_CB_KIND]) begin
                        // Start byte: function, resolution, reset, stop
                        bit_reg <= 5'h00;
                        rm_reg  <= rx_word[`TAC_CB_RM];
                        sts_reg <= rx_word[`TAC_CB_STS];
                        fn_reg  <= rx_word[`TAC_CB_ADDR_HI:`TAC_CB_ADDR_LO];
                        start_reg <= ~rx_word[`TAC_CB_STS] & ~rx_word[`TAC_CB_SWRST];
                        if (rx_word[`TAC_CB_SWRST]) begin
                            psm_reg <= 1'b0;               // Software reset
                            sts_reg <= 1'b0;
                            rm_reg  <= 1'b0;
                            cl_reg  <= 2'h0;
                            pv_reg  <= 3'h0;
                            pr_reg  <= 3'h0;
                            sn_reg  <= 3'h0;
                            dtw_reg <= 1'b0;
                            lsm_reg <= 1'b0;
                            fn_reg  <= 4'h0;
                        end
                    end else begin
                        bit_reg <= bit_reg + 5'd1;
                        // Read of the configuration word loads the shifter
                        if (rx_word[`TAC_CB_ADDR_HI:`TAC_CB_ADDR_LO] == `TAC_CFG_ADDR
                            && rx_word[`TAC_CB_RNW])
                            tx_reg <= rd_word;
                        else
                            tx_reg <= 16'h0000;
                    end
                end else if (bit_reg == 5'd23) begin
                    bit_reg <= 5'h00;                      // Next control byte may follow
                    if (cmd_reg[`TAC_CB_ADDR_HI:`TAC_CB_ADDR_LO] == `TAC_CFG_ADDR
                        && !cmd_reg[`TAC_CB_RNW]) begin
                        psm_reg <= rx_word[`TAC_F_PSM];
                        sts_reg <= rx_word[`TAC_F_STS];
                        rm_reg  <= rx_word[`TAC_F_RM];
                        cl_reg  <= rx_word[`TAC_F_CL_HI:`TAC_F_CL_LO];
                        pv_reg  <= rx_word[`TAC_F_PV_HI:`TAC_F_PV_LO];
                        pr_reg  <= rx_word[`TAC_F_PR_HI:`TAC_F_PR_LO];
                        sn_reg  <= rx_word[`TAC_F_SN_HI:`TAC_F_SN_LO];
                        dtw_reg <= rx_word[`TAC_F_DTW];
                        lsm_reg <= rx_word[`TAC_F_LSM];
                    end
                end else begin
                    bit_reg <= bit_reg + 5'd1;
                end
            end else if (sclk_f && bit_reg >= 5'd8) begin
                spi_miso <= tx_reg[15];                    // MSB first
                tx_reg   <= {tx_reg[14:0], 1'b0};
            end
        end
    end

    // ==========================================================
    // Tick generators
    // ==========================================================
    reg [2:0]  osc_reg;                // Oscillator-rate divider
    reg [1:0]  adc_div_reg;            // Converter clock divider
    reg [7:0]  us_reg;                 // Microsecond divider
    wire osc_tick = (osc_reg == 3'd0);
    wire [1:0] adc_lim = (cl_reg == 2'h0) ? 2'd0 : (cl_reg == 2'h1) ? 2'd1 : 2'd3;
    wire adc_tick = osc_tick & (adc_div_reg == 2'd0);
    wire us_tick  = (us_reg == 8'd0);

    // Free running dividers for oscillator, converter and timer rates
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            osc_reg     <= 3'd0;
            adc_div_reg <= 2'd0;
            us_reg      <= 8'd0;
        end else begin
            osc_reg <= osc_tick ? OSC_LOAD[2:0] : osc_reg - 3'd1;
            if (osc_tick)
                adc_div_reg <= (adc_div_reg == 2'd0) ? adc_lim : adc_div_reg - 2'd1;
            us_reg <= us_tick ? US_LOAD[7:0] : us_reg - 8'd1;
        end
    end

    // ==========================================================
    // Scan sequencer
    // ==========================================================
    reg [5:0]  st_next;                // Next state
    reg [21:0] cnt_next;               // Next countdown
    reg [1:0]  crd_next;               // Next coordinate
    wire [21:0] settle_us = PV_T[pv_reg*22 +: 22];
    wire [21:0] prechg_us = PR_T[pr_reg*22 +: 22];
    wire [21:0] sense_us  = SN_T[sn_reg*22 +: 22];
    // Countdown includes its zero cycle, so the load is one short
    wire [21:0] sample_cy = SAMP_BASE[21:0]
                          + (lsm_reg ? SAMP_LONG[21:0] : 22'd0);
    wire [1:0]  crd_last  = (fn_reg == `TAC_FN_XY) ? 2'd1 : 2'd2;
    wire        scan_fn   = (fn_reg == `TAC_FN_XYZ) || (fn_reg == `TAC_FN_XY);
    wire        dev_start = psm_reg & scan_fn & touch_s;
    wire        cnt_zero  = (cnt_reg == 22'd0);

    // Phase order: settle, sample, convert per coordinate, then precharge and sense
    always @* begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        crd_next = crd_reg;
        case (st_reg)
            ST_IDLE: begin
                if (!sts_reg && (start_reg || dev_start)) begin
                    st_next  = ST_SETTLE;
                    cnt_next = settle_us;
                    crd_next = 2'd0;
                end
            end
            ST_SETTLE: begin
                if (cnt_zero) begin
                    st_next  = ST_SAMPLE;
                    cnt_next = sample_cy;
                end else if (us_tick)
                    cnt_next = cnt_reg - 22'd1;
            end
            ST_SAMPLE: begin
                if (cnt_zero) begin
                    st_next  = ST_CONV;
                    cnt_next = rm_reg ? 22'd12 : 22'd10;
                end else
                    cnt_next = cnt_reg - 22'd1;
            end
            ST_CONV: begin
                if (cnt_zero) begin
                    if (crd_reg == crd_last) begin
                        st_next  = ST_PRECHG;
                        cnt_next = prechg_us;
                    end else begin
                        st_next  = ST_SETTLE;
                        cnt_next = settle_us;
                        crd_next = crd_reg + 2'd1;
                    end
                end else if (adc_tick)
                    cnt_next = cnt_reg - 22'd1;
            end
            ST_PRECHG: begin
                if (cnt_zero) begin
                    st_next  = ST_SENSE;
                    cnt_next = sense_us;
                end else if (us_tick)
                    cnt_next = cnt_reg - 22'd1;
            end
            ST_SENSE: begin
                if (cnt_zero) begin
                    // Device mode keeps scanning while the pen stays down
                    if (psm_reg && touch_s) begin
                        st_next  = ST_SETTLE;
                        cnt_next = settle_us;
                        crd_next = 2'd0;
                    end else
                        st_next = ST_IDLE;
                end else if (us_tick)
                    cnt_next = cnt_reg - 22'd1;
            end
            default: st_next = ST_IDLE;
        endcase
        if (sts_reg) begin
            st_next  = ST_IDLE;
            cnt_next = 22'd0;
        end
    end

    // Sequencer registers and flopped outputs
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg  <= ST_IDLE;
            cnt_reg <= 22'd0;
            crd_reg <= 2'd0;
            data_rdy_reg <= 1'b0;
            panel_drive  <= 1'b0;
            adc_sample   <= 1'b0;
            adc_clk_en   <= 1'b0;
            adc_power    <= 1'b0;
            resolution_select <= 1'b0;
            coord_sel    <= 2'd0;
            conv_done    <= 1'b0;
            touch_data_irq_pin_n <= 1'b1;
        end else begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
            crd_reg <= crd_next;
            conv_done <= st_reg[3] & cnt_zero & ~sts_reg;
            // New result sets, any register command byte, read or write, clears; set wins
            if (st_reg[3] && cnt_zero && !sts_reg)
                data_rdy_reg <= 1'b1;
            else if (sclk_r && bit_reg == 5'd7 && !rx_word[`TAC_CB_KIND])
                data_rdy_reg <= 1'b0;
            panel_drive <= st_next[1] | st_next[2] | st_next[3];
            adc_sample  <= st_next[2];
            adc_clk_en  <= st_reg[3] & adc_tick & ~sts_reg;
            adc_power   <= ~st_next[0] & ~sts_reg;
            resolution_select <= rm_reg;
            coord_sel   <= crd_next;
            // Idle wait detect: pin follows touch alone; otherwise touch or a waiting result pulls it low
            if (st_reg[0] && !psm_reg && dtw_reg)
                touch_data_irq_pin_n <= ~touch_s;
            else
                touch_data_irq_pin_n <= ~(touch_s | data_rdy_reg);
        end
    end

endmodule

`default_nettype wire
